// file: hdl/afe_ctrl_regs.vh
// Offsets, field values and timing counts of the front-end control block.
// Assumes a 200 MHz ref_clk and a host that drives SPI mode 0.
`ifndef AFE_CTRL_REGS_VH
`define AFE_CTRL_REGS_VH

`define ADDR_RESET_KEY 7'h00
`define ADDR_CAL_CLEAR 7'h01
`define ADDR_STREAM 7'h03
`define ADDR_POWER 7'h08
`define ADDR_RESTART 7'h0b
`define ADDR_SCAL_CTRL 7'h10
`define ADDR_STATUS 7'h18
`define ADDR_RESULT_HI 7'h1a
`define ADDR_RESULT_LO 7'h1b
`define ADDR_GAIN 7'h1c
`define ADDR_CAL_FIRST 7'h30
`define ADDR_CAL_LAST 7'h35

`define RESET_KEY 8'hc3
`define INST_URA_WRITE 8'h10
`define INST_URA_READ 8'h90

`define PWR_ACTIVE 2'h0
`define PWR_DOWN 2'h1
`define PWR_STANDBY 2'h3

`define STREAM_TYPE_BIT 7
`define SZ_STREAM 2'h3

`define CLK_PERIOD_PS 5000
`define PWR_LATENCY_NS 15000
`define PWR_LATENCY_CYC ((`PWR_LATENCY_NS * 1000) / `CLK_PERIOD_PS)

`define RESULT_MAX 16'h7fff
`define RESULT_MIN 16'h8000

`endif

// file: hdl/afe_power_reset_spi.v
// Power state, register and conversion reset, result format and SPI register access.
// Assumes the SPI pins are asynchronous to ref_clk and much slower than it,
// and that the converter delivers pre-gain samples already scaled by the reference.
`timescale 1ns/1ps
`include "afe_ctrl_regs.vh"
`default_nettype none

module afe_power_reset_spi #(
	parameter SAMPLE_W = 20,
	parameter BUF_AW = 1,
	parameter PWR_LATENCY = `PWR_LATENCY_CYC
) (
	input wire ref_clk,
	input wire rst,
	input wire sclk,
	input wire chipSelectN,
	input wire mosi,
	output reg misoOut,
	output wire misoOe,
	input wire sampleValid,
	input wire [SAMPLE_W-1:0] sampleIn,
	output wire sampleReady,
	output reg [1:0] powerState,
	output wire convRun,
	output reg convRestart,
	output reg freshResultFlagN,
	output reg [15:0] resultWord
);

	localparam PH_INST = 2'd0;
	localparam PH_URA_WR = 2'd1;
	localparam PH_URA_RD = 2'd2;
	localparam PH_DATA = 2'd3;
	localparam DEPTH = 1 << BUF_AW;
	localparam PROD_W = SAMPLE_W + 8;

	function [15:0] clampResult;
		input signed [PROD_W-1:0] v;
		begin
			if (v > $signed({{(PROD_W-16){1'b0}}, `RESULT_MAX}))
				clampResult = `RESULT_MAX;
			else if (v < $signed({{(PROD_W-16){1'b1}}, `RESULT_MIN}))
				clampResult = `RESULT_MIN;
			else
				clampResult = v[15:0];
		end
	endfunction

	function isCalAddr;
		input [6:0] a;
		begin
			isCalAddr = (a >= `ADDR_CAL_FIRST) && (a <= `ADDR_CAL_LAST);
		end
	endfunction

	// Pin synchronisers; logic reads the second stage, and a third sclk stage for edge detection
	reg sclkMeta_q, sclkSync_q, sclkLast_q;
	reg csMeta_q, csSync_q;
	reg mosiMeta_q, mosiSync_q;

	always @(posedge ref_clk) begin
		if (rst) begin
			sclkMeta_q <= 1'b0;
			sclkSync_q <= 1'b0;
			sclkLast_q <= 1'b0;
			csMeta_q <= 1'b1;
			csSync_q <= 1'b1;
			mosiMeta_q <= 1'b0;
			mosiSync_q <= 1'b0;
		end else begin
			sclkMeta_q <= sclk;
			sclkSync_q <= sclkMeta_q;
			sclkLast_q <= sclkSync_q;
			csMeta_q <= chipSelectN;
			csSync_q <= csMeta_q;
			mosiMeta_q <= mosi;
			mosiSync_q <= mosiMeta_q;
		end
	end

	wire sclkRise = sclkSync_q & ~sclkLast_q;
	wire sclkFall = ~sclkSync_q & sclkLast_q;
	wire csActive = ~csSync_q;

	// SPI transaction state
	reg [1:0] phase_q;
	reg [2:0] bitCnt_q;
	reg [6:0] shiftIn_q;
	reg [2:0] upperRegisterAddress_q;
	reg readWriteN_q;
	reg streamAll_q;
	reg [1:0] bytesLeft_q;
	reg [6:0] addr_q;
	reg [6:0] startAddr_q;
	reg [7:0] txByte_q;
	reg streamTypeSelect_q;
	reg [2:0] streamRegisterCount_q;

	wire [7:0] rxByte = {shiftIn_q, mosiSync_q};
	wire byteDone = sclkRise && csActive && (bitCnt_q == 3'd7);
	wire instDone = byteDone && (phase_q == PH_INST);
	wire isUraInst = (rxByte == `INST_URA_WRITE) || (rxByte == `INST_URA_READ);
	wire dataDone = byteDone && (phase_q == PH_DATA);
	wire inCount = streamAll_q || (bytesLeft_q != 2'd0);
	wire wrEn = dataDone && !readWriteN_q && inCount;
	wire [6:0] instAddr = {upperRegisterAddress_q, rxByte[3:0]};

	// Controlled streaming wraps after the last register of the range;
	// counted bursts never wrap, so they stay on consecutive addresses
	function [6:0] nextAddr;
		input [6:0] a;
		begin
			if (streamTypeSelect_q && streamAll_q
				&& (a == startAddr_q + {4'd0, streamRegisterCount_q}))
				nextAddr = startAddr_q;
			else
				nextAddr = a + 7'd1;
		end
	endfunction

	wire loadRead = (instDone && !isUraInst && rxByte[7]) || (dataDone && readWriteN_q);
	wire [6:0] loadAddr = instDone ? instAddr : nextAddr(addr_q);

	// Register state
	reg [7:0] regFile [0:127];
	reg [1:0] scalMode_q;
	reg keyArmed_q;
	reg [1:0] pwrPending_q;
	reg [12:0] pwrCnt_q;
	reg dropNext_q;
	reg resultLock_q;
	reg [7:0] rdData;
	integer i;

	wire keyWrite = wrEn && (addr_q == `ADDR_RESET_KEY) && (rxByte == `RESET_KEY);
	// In calibration mode the first key only arms; the second one resets
	wire regReset = keyWrite && ((scalMode_q == 2'd0) || keyArmed_q);
	wire restartBit = wrEn && (addr_q == `ADDR_RESTART) && rxByte[0];
	wire calClear = regFile[`ADDR_CAL_CLEAR][0];

	always @* begin
		case (loadAddr)
		`ADDR_RESET_KEY: rdData = 8'h00;
		`ADDR_RESTART: rdData = 8'h00;
		`ADDR_STREAM: rdData = {streamTypeSelect_q, 4'h0, streamRegisterCount_q};
		`ADDR_POWER: rdData = {6'h00, powerState};
		`ADDR_SCAL_CTRL: rdData = {6'h00, scalMode_q};
		`ADDR_STATUS: rdData = {7'h00, freshResultFlagN};
		`ADDR_RESULT_HI: rdData = resultWord[15:8];
		`ADDR_RESULT_LO: rdData = resultWord[7:0];
		default: rdData = regFile[loadAddr];
		endcase
	end

	always @(posedge ref_clk) begin
		if (rst || !csActive) begin
			phase_q <= PH_INST;
			bitCnt_q <= 3'd0;
			shiftIn_q <= 7'h00;
			readWriteN_q <= 1'b0;
			streamAll_q <= 1'b0;
			bytesLeft_q <= 2'd0;
			addr_q <= 7'h00;
			startAddr_q <= 7'h00;
			txByte_q <= 8'h00;
		end else if (sclkRise) begin
			bitCnt_q <= bitCnt_q + 3'd1;
			shiftIn_q <= rxByte[6:0];
			if (byteDone) begin
				case (phase_q)
				PH_INST: begin
					if (rxByte == `INST_URA_WRITE) begin
						phase_q <= PH_URA_WR;
					end else if (rxByte == `INST_URA_READ) begin
						phase_q <= PH_URA_RD;
						txByte_q <= {5'h00, upperRegisterAddress_q};
					end else begin
						phase_q <= PH_DATA;
						readWriteN_q <= rxByte[7];
						streamAll_q <= (rxByte[6:5] == `SZ_STREAM);
						bytesLeft_q <= rxByte[6:5] + 2'd1;
						addr_q <= instAddr;
						startAddr_q <= instAddr;
						txByte_q <= rdData;
					end
				end
				PH_DATA: begin
					if (!streamAll_q && bytesLeft_q != 2'd0)
						bytesLeft_q <= bytesLeft_q - 2'd1;
					addr_q <= loadAddr;
					if (readWriteN_q)
						txByte_q <= inCount ? rdData : 8'h00;
				end
				default: begin
					phase_q <= PH_INST;
					txByte_q <= 8'h00;
				end
				endcase
			end
		end
	end

	// Upper address survives chip select and only changes by its own instruction
	always @(posedge ref_clk) begin
		if (rst)
			upperRegisterAddress_q <= 3'd0;
		else if (byteDone && phase_q == PH_URA_WR)
			upperRegisterAddress_q <= rxByte[2:0];
	end

	// Data out changes on falling edges so the host samples it stable on rising ones
	always @(posedge ref_clk) begin
		if (rst)
			misoOut <= 1'b0;
		else if (sclkFall && csActive)
			misoOut <= txByte_q[3'd7 - bitCnt_q];
	end
	assign misoOe = csActive && ((phase_q == PH_URA_RD) || (phase_q == PH_DATA && readWriteN_q));

	// Register file: calibration registers survive the key unless cleared first
	always @(posedge ref_clk) begin
		if (rst) begin
			for (i = 0; i < 128; i = i + 1)
				regFile[i] <= 8'h00;
			streamTypeSelect_q <= 1'b0;
			streamRegisterCount_q <= 3'd0;
			scalMode_q <= 2'd0;
			keyArmed_q <= 1'b0;
		end else if (regReset) begin
			for (i = 0; i < 128; i = i + 1)
				if (!isCalAddr(i[6:0]) || calClear)
					regFile[i] <= 8'h00;
			streamTypeSelect_q <= 1'b0;
			streamRegisterCount_q <= 3'd0;
			scalMode_q <= 2'd0;
			keyArmed_q <= 1'b0;
		end else if (wrEn) begin
			keyArmed_q <= keyWrite;
			case (addr_q)
			`ADDR_STREAM: begin
				streamTypeSelect_q <= rxByte[`STREAM_TYPE_BIT];
				streamRegisterCount_q <= rxByte[2:0];
			end
			`ADDR_SCAL_CTRL: scalMode_q <= rxByte[1:0];
			`ADDR_RESET_KEY, `ADDR_RESTART, `ADDR_POWER, `ADDR_STATUS,
			`ADDR_RESULT_HI, `ADDR_RESULT_LO: ;
			default: regFile[addr_q] <= rxByte;
			endcase
		end
	end

	// Power state: request is confirmed only after the latency runs out
	wire pwrWrite = wrEn && (addr_q == `ADDR_POWER);
	wire [1:0] pwrCode = rxByte[1:0];
	wire pwrLegal = (pwrCode == `PWR_ACTIVE || pwrCode == `PWR_DOWN || pwrCode == `PWR_STANDBY)
		&& !(powerState == `PWR_DOWN && pwrCode == `PWR_STANDBY);

	always @(posedge ref_clk) begin
		if (rst || regReset) begin
			powerState <= `PWR_ACTIVE;
			pwrPending_q <= `PWR_ACTIVE;
			pwrCnt_q <= 13'd0;
		end else if (pwrCnt_q != 13'd0) begin
			pwrCnt_q <= pwrCnt_q - 13'd1;
			if (pwrCnt_q == 13'd1)
				powerState <= pwrPending_q;
		end else if (pwrWrite && pwrLegal) begin
			pwrPending_q <= pwrCode;
			pwrCnt_q <= PWR_LATENCY[12:0];
		end
	end
	assign convRun = (powerState == `PWR_ACTIVE);

	always @(posedge ref_clk) begin
		if (rst)
			convRestart <= 1'b0;
		else
			convRestart <= regReset || restartBit;
	end

	// Result buffer; a restart flushes samples of the aborted conversion
	reg [15:0] bufMem [0:DEPTH-1];
	reg [BUF_AW-1:0] wrPtr_q, rdPtr_q;
	reg [BUF_AW:0] bufCnt_q;
	wire flush = regReset || restartBit || !convRun;
	wire bufFull = (bufCnt_q == DEPTH);
	wire bufEmpty = (bufCnt_q == 0);
	assign sampleReady = !bufFull && convRun;
	wire push = sampleValid && sampleReady;
	wire pop = !bufEmpty && !resultLock_q;
	wire signed [PROD_W-1:0] scaled =
		$signed({{8{sampleIn[SAMPLE_W-1]}}, sampleIn}) <<< regFile[`ADDR_GAIN][2:0];

	always @(posedge ref_clk) begin
		if (rst || flush) begin
			wrPtr_q <= {BUF_AW{1'b0}};
			rdPtr_q <= {BUF_AW{1'b0}};
			bufCnt_q <= {(BUF_AW+1){1'b0}};
		end else begin
			if (push) begin
				bufMem[wrPtr_q] <= clampResult(scaled);
				wrPtr_q <= wrPtr_q + 1'b1;
			end
			if (pop)
				rdPtr_q <= rdPtr_q + 1'b1;
			if (push && !pop)
				bufCnt_q <= bufCnt_q + 1'b1;
			else if (pop && !push)
				bufCnt_q <= bufCnt_q - 1'b1;
		end
	end

	// A result pair being read is held steady until its low byte is loaded or chip select goes high
	wire loadHi = loadRead && loadAddr == `ADDR_RESULT_HI;
	wire loadLo = loadRead && loadAddr == `ADDR_RESULT_LO;
	wire popGood = pop && !flush && !dropNext_q;

	always @(posedge ref_clk) begin
		if (rst) begin
			resultLock_q <= 1'b0;
			dropNext_q <= 1'b0;
			resultWord <= 16'h0000;
		end else begin
			if (loadHi)
				resultLock_q <= 1'b1;
			else if (loadLo || !csActive)
				resultLock_q <= 1'b0;
			if (restartBit)
				dropNext_q <= 1'b1;
			else if (pop && !flush)
				dropNext_q <= 1'b0;
			if (popGood)
				resultWord <= bufMem[rdPtr_q];
		end
	end

	// Not touched by the key; new data wins over a read in the same cycle
	always @(posedge ref_clk) begin
		if (rst)
			freshResultFlagN <= 1'b1;
		else if (popGood)
			freshResultFlagN <= 1'b0;
		else if (loadHi)
			freshResultFlagN <= 1'b1;
	end

endmodule

`default_nettype wire

// file: tb/afe_ctrl_asserts.sv
// Concurrent checks on the ports of the front-end control block.
// Assumes it is bound to afe_power_reset_spi with a power latency above 8 cycles.
`timescale 1ns/1ps
`include "afe_ctrl_regs.vh"
`default_nettype none
module afe_ctrl_asserts (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic chipSelectN,
	input wire logic misoOe,
	input wire logic sampleReady,
	input wire logic [1:0] powerState,
	input wire logic convRun,
	input wire logic convRestart,
	input wire logic freshResultFlagN,
	input wire logic [15:0] resultWord
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Six cycles leave room for the two-stage select synchroniser
	sequence s_cs_idle;
		chipSelectN [*6];
	endsequence
	sequence s_state_moved;
		$changed(powerState);
	endsequence
	property p_code; powerState != 2'h2; endproperty
	property p_no_skip; $past(powerState) == `PWR_DOWN |-> powerState != `PWR_STANDBY; endproperty
	property p_hold; s_state_moved |=> $stable(powerState) [*8]; endproperty
	property p_run; convRun == (powerState == `PWR_ACTIVE); endproperty
	property p_ready; sampleReady |-> convRun; endproperty
	property p_pulse; convRestart |=> !convRestart; endproperty
	property p_miso; s_cs_idle |-> !misoOe; endproperty
	property p_fresh; $changed(resultWord) |-> !freshResultFlagN; endproperty
	a_code: assert property (p_code) else $error("illegal power code");
	a_no_skip: assert property (p_no_skip) else $error("power-down went to stand-by");
	a_hold: assert property (p_hold) else $error("power state moved again");
	a_run: assert property (p_run) else $error("run flag off state");
	a_ready: assert property (p_ready) else $error("ready while idle");
	a_pulse: assert property (p_pulse) else $error("restart pulse too long");
	a_miso: assert property (p_miso) else $error("output driven while deselected");
	a_fresh: assert property (p_fresh) else $error("new result not flagged");
endmodule
bind afe_power_reset_spi afe_ctrl_asserts u_chk (
	.ref_clk(ref_clk),
	.rst(rst),
	.chipSelectN(chipSelectN),
	.misoOe(misoOe),
	.sampleReady(sampleReady),
	.powerState(powerState),
	.convRun(convRun),
	.convRestart(convRestart),
	.freshResultFlagN(freshResultFlagN),
	.resultWord(resultWord)
);
`default_nettype wire

// file: tb/spi_host_model.sv
// SPI host model: mode 0 bytes on its own 48 ns serial clock.
// Assumes the device drives misoOut only while misoOe is high.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	output logic sclk,
	output logic chipSelectN,
	output logic mosi,
	input wire logic misoOut,
	input wire logic misoOe
);
	logic [7:0] rx;
	initial begin
		sclk = 0;
		chipSelectN = 1;
		mosi = 0;
	end
	// Clock stands low between bytes; an unread line shows up as unknown
	task xfer(input logic [7:0] tx);
		for (int i = 7; i >= 0; i--) begin
			mosi = tx[i];
			#24 sclk = 1;
			rx = {rx[6:0], misoOe ? misoOut : 1'bx};
			#24 sclk = 0;
		end
		mosi = ~mosi;
	endtask
	task frame(input logic high);
		#48 chipSelectN = high;
	endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the front-end control block.
// Assumes a 600-cycle power latency and the host model for SPI frames.
`timescale 1ns/1ps
`include "afe_ctrl_regs.vh"
`default_nettype none
module tb;
	logic ref_clk = 0;
	logic rst = 1;
	logic sampleValid = 0;
	logic restartSeen = 0;
	logic [19:0] sampleIn = 0;
	wire sclk, chipSelectN, mosi, misoOut, misoOe, sampleReady, convRun, convRestart;
	wire freshResultFlagN;
	wire [1:0] powerState;
	wire [15:0] resultWord;
	int error_cnt = 0;
	int num_checks = 0;
	logic [7:0] rd [6];
	// Sample, gain code, expected result
	logic [39:0] rows [7] = '{40'h0123401234, 40'h01234248d0, 40'h1000007fff, 40'hf000008000,
		40'hfffff3fff8, 40'h07fff17fff, 40'h0000170080};
	always #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (convRestart) restartSeen <= 1;
	afe_power_reset_spi #(.PWR_LATENCY(600)) uut (
		.ref_clk(ref_clk),
		.rst(rst),
		.sclk(sclk),
		.chipSelectN(chipSelectN),
		.mosi(mosi),
		.misoOut(misoOut),
		.misoOe(misoOe),
		.sampleValid(sampleValid),
		.sampleIn(sampleIn),
		.sampleReady(sampleReady),
		.powerState(powerState),
		.convRun(convRun),
		.convRestart(convRestart),
		.freshResultFlagN(freshResultFlagN),
		.resultWord(resultWord)
	);
	spi_host_model host (
		.sclk(sclk),
		.chipSelectN(chipSelectN),
		.mosi(mosi),
		.misoOut(misoOut),
		.misoOe(misoOe)
	);
	task complete_run(input logic hang);
		error_cnt += hang;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Optional upper address setup, then one access frame of n bytes through rd
	task acc(input logic u, input logic [6:0] a, input logic [7:0] inst, input int n);
		if (u) begin
			host.frame(0);
			host.xfer(`INST_URA_WRITE);
			host.xfer({5'h0, a[6:4]});
			host.frame(1);
		end
		host.frame(0);
		host.xfer(inst | {4'h0, a[3:0]});
		for (int i = 0; i < n; i++) begin
			host.xfer(rd[i]);
			if (inst[7]) rd[i] = host.rx;
		end
		host.frame(1);
	endtask
	task wr(input logic [6:0] a, input logic [7:0] d);
		rd[0] = d;
		acc(1, a, 8'h00, 1);
	endtask
	task push(input logic [19:0] s);
		int k;
		@(posedge ref_clk) #1;
		sampleIn = s;
		sampleValid = 1;
		for (k = 0; k < 200 && sampleReady !== 1'b1; k++) @(posedge ref_clk) #1;
		if (k == 200) complete_run(1);
		@(posedge ref_clk) #1;
		sampleValid = 0;
		repeat (4) @(posedge ref_clk);
	endtask
	// Waits out the latency before looking, as a host must
	task pw(input logic [1:0] code, input logic [1:0] exp);
		wr(`ADDR_POWER, {6'h0, code});
		repeat (700) @(posedge ref_clk);
		chk({14'h0, powerState}, {14'h0, exp});
		chk({15'h0, convRun}, {15'h0, exp == `PWR_ACTIVE});
	endtask
	initial begin
		repeat (20) @(posedge ref_clk);
		#1 rst = 0;
		repeat (4) @(posedge ref_clk);
		chk({14'h0, powerState}, {14'h0, `PWR_ACTIVE});
		chk({15'h0, freshResultFlagN}, 16'h1);
		foreach (rows[i]) begin
			wr(`ADDR_GAIN, {4'h0, rows[i][19:16]});
			push(rows[i][39:20]);
			chk(resultWord, rows[i][15:0]);
			chk({15'h0, freshResultFlagN}, 16'h0);
			acc(1, `ADDR_RESULT_HI, 8'ha0, 2);
			chk({rd[0], rd[1]}, rows[i][15:0]);
			chk({15'h0, freshResultFlagN}, 16'h1);
		end
		wr(`ADDR_POWER, {6'h0, `PWR_STANDBY});
		// A second request inside the latency must not displace the first
		rd[0] = {6'h0, `PWR_DOWN};
		acc(0, `ADDR_POWER, 8'h00, 1);
		chk({14'h0, powerState}, {14'h0, `PWR_ACTIVE});
		repeat (700) @(posedge ref_clk);
		chk({14'h0, powerState}, {14'h0, `PWR_STANDBY});
		acc(1, `ADDR_POWER, 8'h80, 1);
		chk({8'h0, rd[0]}, 16'h0003);
		pw(`PWR_ACTIVE, `PWR_ACTIVE);
		pw(`PWR_DOWN, `PWR_DOWN);
		pw(`PWR_STANDBY, `PWR_DOWN);
		wr(`ADDR_RESET_KEY, `RESET_KEY);
		repeat (4) @(posedge ref_clk);
		chk({15'h0, restartSeen}, 16'h1);
		chk({14'h0, powerState}, {14'h0, `PWR_ACTIVE});
		wr(`ADDR_RESTART, 8'h01);
		push(20'h00011);
		push(20'h00022);
		chk(resultWord, 16'h0022);
		wr(`ADDR_STREAM, 8'h81);
		acc(1, `ADDR_RESULT_HI, 8'he0, 6);
		for (int i = 0; i < 6; i++) chk({8'h0, rd[i]}, i % 2 ? 16'h0022 : 16'h0000);
		rd = '{8'h11, 8'h22, 8'h33, 8'h0, 8'h0, 8'h0};
		acc(1, 7'h30, 8'h40, 3);
		host.frame(0);
		host.xfer(`INST_URA_READ);
		host.xfer(8'h00);
		host.frame(1);
		chk({8'h0, host.rx}, 16'h0003);
		acc(0, 7'h30, 8'hc0, 3);
		chk({rd[0], rd[2]}, 16'h1133);
		wr(`ADDR_RESET_KEY, `RESET_KEY);
		acc(1, 7'h31, 8'h80, 1);
		chk({8'h0, rd[0]}, 16'h0022);
		wr(`ADDR_CAL_CLEAR, 8'h01);
		wr(`ADDR_RESET_KEY, `RESET_KEY);
		acc(1, 7'h31, 8'h80, 1);
		chk({8'h0, rd[0]}, 16'h0000);
		wr(`ADDR_SCAL_CTRL, 8'h01);
		wr(`ADDR_RESET_KEY, `RESET_KEY);
		acc(1, `ADDR_SCAL_CTRL, 8'h80, 1);
		chk({8'h0, rd[0]}, 16'h0001);
		wr(`ADDR_RESET_KEY, `RESET_KEY);
		acc(1, `ADDR_SCAL_CTRL, 8'h80, 1);
		chk({8'h0, rd[0]}, 16'h0000);
		// Mid-run reset must bring back normal streaming
		wr(`ADDR_STREAM, 8'h81);
		@(posedge ref_clk) #1 rst = 1;
		repeat (4) @(posedge ref_clk);
		#1 rst = 0;
		repeat (4) @(posedge ref_clk);
		chk({15'h0, freshResultFlagN}, 16'h1);
		acc(1, `ADDR_STREAM, 8'h80, 1);
		chk({8'h0, rd[0]}, 16'h0000);
		complete_run(0);
	end
endmodule
`default_nettype wire
